/* File: afe_unit.sv */
// Functional notes
// - Bus error via transfer error input handled like internal fault, flagged as bus.
// - Bus error on data write always raises access fault at once.
// - Bus error on single read or first line beat raises fault at once.
// - Later line beat error aborts line; faults only if that word requested.
// - Prefetch bus error waits for use; new flow discards it.
// - Push fault idles unit, freezes pipe, cancels caches, stacks writes.
// - Data fault waits unit idle (bus idle too unless bus error), freezes, cancels icache, stacks writes.
// - Write protect, supervisor only or nonresident violation raises internal fault.
// - Translation miss walks tables; retry faults only on invalid or bus error.
// - Bring unit idle, then take only the highest priority exception.
// - Report faults after earlier instructions; their exception drops the fault.
// - Data fault lets current prefetch bus cycle finish first.
// - Copy status word, set supervisor, clear both trace bits, vector 2.
// - Stacked program counter is instruction executing at detection.
// - Frame holds address, pending write-backs up to three, move-multiple state.
// - Bus error while stacking or return reload halts with status code 5.
// - Halted core never writes memory; only reset restarts it.
// - Odd prefetch address raises address error and suppresses the bus cycle.
// - Address error waits earlier instructions; their exception drops it.
// - Address error uses vector 3; frame holds address with low bit cleared.
// - Address error during fault, address error or reset processing halts.
// - Frame status bit separates external bus error from internal fault.
// - Vector address is table base plus vector number times four.
`timescale 1ns/1ps
`include "afe_map.svh"

module afe_unit
  import afe_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // External bus cycle
  input wire logic TRANSFER_ERROR_ACK_IN,
  input wire afe_cycle_type BUS_CYCLE,
  input wire logic BUS_IDLE,
  input wire logic PREFETCH_CYC_BUSY,
  // Execution unit
  input wire logic [3:0] EU_REQ_MASK,
  input wire logic EU_IDLE,
  input wire logic EARLIER_PENDING,
  input wire logic EARLIER_EXC,
  input wire logic [31:0] CUR_PC,
  input wire logic [15:0] STATUS_WORD_IN,
  input wire logic [1:0] PEND_WRITES,
  input wire logic [7:0] MOVE_MULTIPLE_STATE,
  input wire logic STACK_DONE,
  input wire logic RTE_RELOAD,
  input wire logic RESET_EXC_ACTIVE,
  // Prefetch
  input wire logic PREFETCH_REQ,
  input wire logic [31:0] PREFETCH_ADDR,
  input wire logic PREFETCH_USE,
  input wire logic CHANGE_OF_FLOW,
  // Translation
  input wire logic XLAT_VALID,
  input wire logic XLAT_MISS,
  input wire logic XLAT_WRITE,
  input wire logic XLAT_SUPER_ACC,
  input wire logic PAGE_WP,
  input wire logic PAGE_SUPER,
  input wire logic PAGE_RESIDENT,
  input wire logic XLAT_RETRY,
  input wire logic WALK_INVALID,
  input wire logic PUSH_FAULT,
  // Control outputs
  output logic PREFETCH_GO,
  output logic LINE_ABORT,
  output logic WALK_START,
  output logic IDLE_EU_REQ,
  output logic FREEZE_PIPE,
  output logic CANCEL_ICACHE,
  output logic CANCEL_DCACHE,
  output logic STACK_WRITES,
  output logic FAULT_DROPPED,
  output logic EXC_ACTIVE,
  output logic [7:0] VECTOR_NUM,
  output logic [31:0] VECTOR_ADDR,
  output logic [15:0] STATUS_WORD_OUT,
  output logic MEM_WRITE_INHIBIT,
  output logic HALTED,
  output logic [3:0] PROCESSOR_STATUS_CODE
);

  afe_state_type state_q, state_d;
  afe_fault_type fault_q, new_fault;
  afe_cycle_type cyc_s1_q, cyc_s2_q;
  logic tea_s1_q, tea_s2_q;
  logic pref_err_q, walk_bad_q;
  logic [31:0] vbase_q;
  logic [15:0] sr_copy_q;
  logic new_valid, drain_ok, tea_hit, odd_fetch, prot_fault, int_fault;
  logic data_bus_fault, double_fault, apb_access, apb_hit;
  logic [31:0] rd_word;
  logic [7:0] vec_num;

  // Pin synchroniser; cycle info delayed alike to stay aligned
  always_ff @(posedge CLK) begin
    if (RST) begin
      tea_s1_q <= 1'b0;
      tea_s2_q <= 1'b0;
      cyc_s1_q <= '0;
      cyc_s2_q <= '0;
    end else begin
      tea_s1_q <= TRANSFER_ERROR_ACK_IN;
      tea_s2_q <= tea_s1_q;
      cyc_s1_q <= BUS_CYCLE;
      cyc_s2_q <= cyc_s1_q;
    end
  end

  assign tea_hit = tea_s2_q && (cyc_s2_q.kind != CYC_NONE);
  assign data_bus_fault = tea_s2_q && ((cyc_s2_q.kind == CYC_WRITE) || (cyc_s2_q.kind == CYC_READ) ||
                          ((cyc_s2_q.kind == CYC_LINE) &&
                           ((cyc_s2_q.beat == 2'd0) || EU_REQ_MASK[cyc_s2_q.beat])));
  assign odd_fetch = PREFETCH_REQ && PREFETCH_ADDR[0];
  assign prot_fault = XLAT_VALID && !XLAT_MISS &&
                      ((PAGE_WP && XLAT_WRITE) || (PAGE_SUPER && !XLAT_SUPER_ACC) || !PAGE_RESIDENT);
  assign int_fault = prot_fault || (XLAT_RETRY && walk_bad_q);

  assign double_fault = (state_q == ST_STACK && (tea_hit || odd_fetch || int_fault || PUSH_FAULT)) ||
                        (RTE_RELOAD && tea_hit) ||
                        (RESET_EXC_ACTIVE && (tea_hit || odd_fetch));

  // highest priority wins; access fault before address error
  always_comb begin
    new_valid = 1'b1;
    new_fault.bus_err = 1'b0;
    new_fault.cls = FC_DATA;
    new_fault.addr = cyc_s2_q.addr;
    new_fault.pc = CUR_PC;
    new_fault.pend = PEND_WRITES;
    new_fault.move_multiple_op = MOVE_MULTIPLE_STATE;
    if (PUSH_FAULT) begin
      new_fault.cls = FC_PUSH;
    end else if (data_bus_fault) begin
      new_fault.bus_err = 1'b1;
    end else if (int_fault) begin
      new_fault.cls = FC_DATA;
    end else if (PREFETCH_USE && pref_err_q) begin
      new_fault.bus_err = 1'b1;
      new_fault.cls = FC_INSTR;
    end else if (odd_fetch) begin
      new_fault.cls = FC_ADDR;
      new_fault.addr = {PREFETCH_ADDR[31:1], 1'b0};
    end else begin
      new_valid = 1'b0;
    end
  end

  // deferred prefetch error; set beats a same-cycle flush
  always_ff @(posedge CLK) begin
    if (RST) begin
      pref_err_q <= 1'b0;
    end else if (tea_hit && cyc_s2_q.kind == CYC_FETCH) begin
      pref_err_q <= 1'b1;
    end else if (CHANGE_OF_FLOW || (PREFETCH_USE && state_q == ST_IDLE)) begin
      pref_err_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      walk_bad_q <= 1'b0;
    end else if ((tea_hit && cyc_s2_q.kind == CYC_WALK) || WALK_INVALID) begin
      walk_bad_q <= 1'b1;
    end else if (XLAT_RETRY) begin
      walk_bad_q <= 1'b0;
    end
  end

  always_comb begin
    drain_ok = EU_IDLE && !EARLIER_PENDING;
    if (fault_q.cls == FC_DATA && !fault_q.bus_err) begin
      drain_ok = drain_ok && BUS_IDLE && !PREFETCH_CYC_BUSY;
    end else if (fault_q.cls == FC_DATA) begin
      drain_ok = drain_ok && !PREFETCH_CYC_BUSY;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (double_fault) begin
          state_d = ST_HALT;
        end else if (new_valid) begin
          state_d = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (double_fault) begin
          state_d = ST_HALT;
        end else if (EARLIER_EXC) begin
          state_d = ST_IDLE;
        end else if (drain_ok) begin
          state_d = ST_STACK;
        end
      end
      ST_STACK: begin
        if (double_fault) begin
          state_d = ST_HALT;
        end else if (STACK_DONE) begin
          state_d = ST_IDLE;
        end
      end
      ST_HALT: state_d = ST_HALT;
      default: state_d = ST_HALT;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fault_q <= '0;
    end else if (state_q == ST_IDLE && new_valid) begin
      fault_q <= new_fault;
    end
  end

  assign vec_num = (fault_q.cls == FC_ADDR) ? `AFE_VEC_ADDRESS : `AFE_VEC_ACCESS;

  // status copy, supervisor on, trace off
  always_ff @(posedge CLK) begin
    if (RST) begin
      sr_copy_q <= 16'h0000;
      STATUS_WORD_OUT <= 16'h0000;
      VECTOR_NUM <= 8'h00;
      VECTOR_ADDR <= 32'h0000_0000;
    end else if (state_q == ST_DRAIN && state_d == ST_STACK) begin
      sr_copy_q <= STATUS_WORD_IN;
      STATUS_WORD_OUT <= STATUS_WORD_IN;
      STATUS_WORD_OUT[`AFE_SR_SUPER] <= 1'b1;
      STATUS_WORD_OUT[`AFE_SR_TRACE_HIGH] <= 1'b0;
      STATUS_WORD_OUT[`AFE_SR_TRACE_LOW] <= 1'b0;
      VECTOR_NUM <= vec_num;
      VECTOR_ADDR <= vbase_q + {22'h000000, vec_num, 2'b00};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      IDLE_EU_REQ <= 1'b0;
      FREEZE_PIPE <= 1'b0;
      CANCEL_ICACHE <= 1'b0;
      CANCEL_DCACHE <= 1'b0;
      STACK_WRITES <= 1'b0;
    end else begin
      IDLE_EU_REQ <= state_d == ST_DRAIN || state_d == ST_STACK;
      FREEZE_PIPE <= (state_d == ST_DRAIN || state_d == ST_STACK) && state_d != ST_IDLE &&
                     ((state_q == ST_IDLE ? new_fault.cls : fault_q.cls) inside {FC_PUSH, FC_DATA});
      CANCEL_ICACHE <= state_d == ST_DRAIN &&
                       ((state_q == ST_IDLE ? new_fault.cls : fault_q.cls) inside {FC_PUSH, FC_DATA});
      CANCEL_DCACHE <= state_d == ST_DRAIN &&
                       ((state_q == ST_IDLE ? new_fault.cls : fault_q.cls) == FC_PUSH);
      STACK_WRITES <= state_d == ST_STACK && fault_q.cls inside {FC_PUSH, FC_DATA};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PREFETCH_GO <= 1'b0;
      LINE_ABORT <= 1'b0;
      WALK_START <= 1'b0;
      FAULT_DROPPED <= 1'b0;
    end else begin
      PREFETCH_GO <= PREFETCH_REQ && !PREFETCH_ADDR[0] && state_d != ST_HALT;
      LINE_ABORT <= tea_s2_q && cyc_s2_q.kind == CYC_LINE && cyc_s2_q.beat != 2'd0;
      WALK_START <= XLAT_VALID && XLAT_MISS && state_d != ST_HALT;
      FAULT_DROPPED <= state_q == ST_DRAIN && state_d == ST_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      EXC_ACTIVE <= 1'b0;
      HALTED <= 1'b0;
      MEM_WRITE_INHIBIT <= 1'b0;
      PROCESSOR_STATUS_CODE <= `AFE_PST_RUN;
    end else begin
      EXC_ACTIVE <= state_d == ST_STACK;
      HALTED <= state_d == ST_HALT;
      MEM_WRITE_INHIBIT <= state_d == ST_HALT;
      if (state_d == ST_HALT) begin
        PROCESSOR_STATUS_CODE <= `AFE_PST_HALT;
      end else if (state_d == ST_STACK) begin
        PROCESSOR_STATUS_CODE <= `AFE_PST_EXC;
      end else begin
        PROCESSOR_STATUS_CODE <= `AFE_PST_RUN;
      end
    end
  end

  // APB: one wait state, answer on second access cycle
  assign apb_access = PSEL && PENABLE && PREADY;
  always_comb begin
    apb_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (PADDR)
      `AFE_OFF_VBASE: rd_word = vbase_q;
      `AFE_OFF_STATUS: rd_word = {27'h0000000, state_q, HALTED};
      `AFE_OFF_FADDR: rd_word = fault_q.addr;
      `AFE_OFF_SPC: rd_word = fault_q.pc;
      `AFE_OFF_FRAME: begin
        rd_word[`AFE_FRM_SR_LSB +: 16] = sr_copy_q;
        rd_word[`AFE_FRM_VEC_LSB +: 8] = vec_num;
        rd_word[`AFE_FRM_PEND_LSB +: 2] = fault_q.pend;
        rd_word[`AFE_FRM_BUSERR] = fault_q.bus_err;
        rd_word[`AFE_FRM_ADDRERR] = fault_q.cls == FC_ADDR;
      end
      `AFE_OFF_MOVE_MULTIPLE_OP: rd_word = {24'h000000, fault_q.move_multiple_op};
      default: apb_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rd_word : 32'h0000_0000;
      PSLVERR <= PSEL && PENABLE && !PREADY && !apb_hit;
    end
  end

  // Base writable any time; read-only offsets ignore writes
  always_ff @(posedge CLK) begin
    if (RST) begin
      vbase_q <= `AFE_VBASE_RST;
    end else if (apb_access && PWRITE && PADDR == `AFE_OFF_VBASE) begin
      vbase_q <= PWDATA;
    end
  end

endmodule // afe_unit

/* File: afe_map.svh */
`ifndef AFE_MAP_SVH
`define AFE_MAP_SVH

// Register byte offsets on the APB slave
`define AFE_OFF_VBASE 12'h000
`define AFE_OFF_STATUS 12'h004
`define AFE_OFF_FADDR 12'h008
`define AFE_OFF_SPC 12'h00C
`define AFE_OFF_FRAME 12'h010
`define AFE_OFF_MOVE_MULTIPLE_OP 12'h014

// Reset values
`define AFE_VBASE_RST 32'h0000_0000

// Status word field positions
`define AFE_SR_TRACE_HIGH 15
`define AFE_SR_TRACE_LOW 14
`define AFE_SR_SUPER 13

// Frame info register field positions
`define AFE_FRM_SR_LSB 0
`define AFE_FRM_VEC_LSB 16
`define AFE_FRM_PEND_LSB 24
`define AFE_FRM_BUSERR 26
`define AFE_FRM_ADDRERR 27

// Vector numbers and the vector scale shift
`define AFE_VEC_ACCESS 8'h02
`define AFE_VEC_ADDRESS 8'h03
`define AFE_VEC_SHIFT 2

// Processor status codes
`define AFE_PST_RUN 4'h0
`define AFE_PST_EXC 4'h1
`define AFE_PST_HALT 4'h5

`endif

/* File: afe_pkg.sv */
package afe_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DRAIN = 4'b0010,
    ST_STACK = 4'b0100,
    ST_HALT  = 4'b1000
  } afe_state_type;

  typedef enum logic [2:0] {
    CYC_NONE  = 3'h0,
    CYC_WRITE = 3'h1,
    CYC_READ  = 3'h2,
    CYC_LINE  = 3'h3,
    CYC_FETCH = 3'h4,
    CYC_WALK  = 3'h5
  } afe_cyc_type;

  typedef enum logic [1:0] {
    FC_PUSH  = 2'h0,
    FC_DATA  = 2'h1,
    FC_INSTR = 2'h2,
    FC_ADDR  = 2'h3
  } afe_class_type;

  typedef struct packed {
    logic bus_err;
    afe_class_type cls;
    logic [31:0] addr;
    logic [31:0] pc;
    logic [1:0] pend;
    logic [7:0] move_multiple_op;
  } afe_fault_type;

  typedef struct packed {
    afe_cyc_type kind;
    logic [1:0] beat;
    logic [31:0] addr;
  } afe_cycle_type;

endpackage

/* File: afe_chk_sva.sv */
`timescale 1ns/1ps
module afe_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Causes
  input wire logic PUSH_FAULT,
  input wire logic PREFETCH_REQ,
  input wire logic [31:0] PREFETCH_ADDR,
  input wire logic XLAT_VALID,
  input wire logic XLAT_MISS,
  // Results
  input wire logic PREFETCH_GO,
  input wire logic LINE_ABORT,
  input wire logic WALK_START,
  input wire logic IDLE_EU_REQ,
  input wire logic FREEZE_PIPE,
  input wire logic CANCEL_ICACHE,
  input wire logic CANCEL_DCACHE,
  input wire logic STACK_WRITES,
  input wire logic EXC_ACTIVE,
  input wire logic [15:0] STATUS_WORD_OUT,
  input wire logic MEM_WRITE_INHIBIT,
  input wire logic HALTED,
  input wire logic [3:0] PROCESSOR_STATUS_CODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_push;
    PUSH_FAULT && !EXC_ACTIVE && !IDLE_EU_REQ && !HALTED |=> IDLE_EU_REQ && FREEZE_PIPE && CANCEL_ICACHE && CANCEL_DCACHE;
  endproperty
  a_push: assert property (p_push)
    else $error("push fault not drained");
  // Push and data faults cancel the icache in drain; others never stack writes
  logic dat_q;
  always_ff @(posedge CLK) begin
    if (RST || !IDLE_EU_REQ) begin
      dat_q <= 1'b0;
    end else if (CANCEL_ICACHE) begin
      dat_q <= 1'b1;
    end
  end
  property p_stk;
    EXC_ACTIVE |-> STACK_WRITES == dat_q && FREEZE_PIPE == dat_q && PROCESSOR_STATUS_CODE == 4'h1;
  endproperty
  a_stk: assert property (p_stk)
    else $error("stacking without freeze");
  property p_sr;
    EXC_ACTIVE |-> STATUS_WORD_OUT[13] && STATUS_WORD_OUT[15:14] == 2'h0;
  endproperty
  a_sr: assert property (p_sr)
    else $error("status word not supervisor");
  property p_code;
    HALTED |-> PROCESSOR_STATUS_CODE == 4'h5 && MEM_WRITE_INHIBIT && !EXC_ACTIVE;
  endproperty
  a_code: assert property (p_code)
    else $error("halt code wrong");
  property p_stay;
    HALTED |=> HALTED;
  endproperty
  a_stay: assert property (p_stay)
    else $error("left halt without reset");
  property p_mem;
    HALTED |-> !PREFETCH_GO && !WALK_START;
  endproperty
  a_mem: assert property (p_mem)
    else $error("bus activity while halted");
  property p_odd;
    PREFETCH_REQ && PREFETCH_ADDR[0] |=> !PREFETCH_GO;
  endproperty
  a_odd: assert property (p_odd)
    else $error("odd prefetch ran");
  property p_even;
    PREFETCH_REQ && !PREFETCH_ADDR[0] && !HALTED && !EXC_ACTIVE && !IDLE_EU_REQ |=> PREFETCH_GO;
  endproperty
  a_even: assert property (p_even)
    else $error("even prefetch blocked");
  property p_walk;
    XLAT_VALID && XLAT_MISS && !HALTED && !EXC_ACTIVE && !IDLE_EU_REQ |=> WALK_START;
  endproperty
  a_walk: assert property (p_walk)
    else $error("no table walk on miss");
  c_push: cover property (PUSH_FAULT ##1 IDLE_EU_REQ);
  c_halt: cover property ($rose(HALTED));
  c_line: cover property (LINE_ABORT);
endmodule // afe_chk

bind afe_unit afe_chk u_afe_chk (.*);

/* File: afe_bus_model.sv */
`timescale 1ns/1ps
module afe_bus_model
  import afe_pkg::*;
(
  // Clock
  input wire logic CLK,
  // Bus side
  output logic TRANSFER_ERROR_ACK_IN,
  output afe_cycle_type BUS_CYCLE
);
  initial begin
    TRANSFER_ERROR_ACK_IN = 1'b0;
    BUS_CYCLE = '0;
  end
  task run(input afe_cyc_type k, input int n, input int eb);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      BUS_CYCLE <= '{k, i[1:0], 32'h0000_4000 + 32'(i * 4)};
      TRANSFER_ERROR_ACK_IN <= (i == eb);
      if (i == eb) break;
    end
    @(posedge CLK);
    // Released address flips so stale values never look valid
    BUS_CYCLE <= '{CYC_NONE, 2'h0, ~BUS_CYCLE.addr};
    TRANSFER_ERROR_ACK_IN <= 1'b0;
  endtask
endmodule // afe_bus_model

/* File: tb_access_fault_address_error_unit.sv */
`timescale 1ns/1ps
`include "afe_map.svh"
module tb_access_fault_address_error_unit;
  import afe_pkg::*;
  localparam logic [31:0] VB = 32'h0000_1000;
  logic CLK = 0, RST = 1;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, CUR_PC, PREFETCH_ADDR, VECTOR_ADDR, rd;
  logic TRANSFER_ERROR_ACK_IN;
  afe_cycle_type BUS_CYCLE;
  logic BUS_IDLE, PREFETCH_CYC_BUSY, EU_IDLE, EARLIER_PENDING, EARLIER_EXC, STACK_DONE, RTE_RELOAD;
  logic RESET_EXC_ACTIVE, PREFETCH_REQ, PREFETCH_USE, CHANGE_OF_FLOW, XLAT_VALID, XLAT_MISS, XLAT_WRITE;
  logic XLAT_SUPER_ACC, PAGE_WP, PAGE_SUPER, PAGE_RESIDENT, XLAT_RETRY, WALK_INVALID, PUSH_FAULT;
  logic PREFETCH_GO, LINE_ABORT, WALK_START, IDLE_EU_REQ, FREEZE_PIPE, CANCEL_ICACHE, CANCEL_DCACHE;
  logic STACK_WRITES, FAULT_DROPPED, EXC_ACTIVE, MEM_WRITE_INHIBIT, HALTED, er, la = 0, fd = 0;
  logic [3:0] EU_REQ_MASK, PROCESSOR_STATUS_CODE;
  logic [15:0] STATUS_WORD_IN, STATUS_WORD_OUT;
  logic [1:0] PEND_WRITES;
  logic [7:0] MOVE_MULTIPLE_STATE, VECTOR_NUM;
  int error_cnt = 0, cmp_count = 0;

  afe_unit u_afe_unit (.*);
  afe_bus_model u_afe_bus_model (.*);

  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    la <= la | LINE_ABORT;
    fd <= fd | FAULT_DROPPED;
  end

  task report_and_stop;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK) {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLK) PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (n > 20) begin
        error_cnt++;
        report_and_stop;
      end
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask

  task wt(input bit h);
    int n;
    n = 0;
    while ((h ? HALTED : EXC_ACTIVE) !== 1'b1) begin
      @(posedge CLK);
      n++;
      if (n > 60) begin
        error_cnt++;
        report_and_stop;
      end
    end
  endtask

  task ex(input logic [7:0] v);
    wt(0);
    chk(VECTOR_NUM, v);
    chk(VECTOR_ADDR, VB + {v, 2'b00});
    chk(STATUS_WORD_OUT, 16'h20FF);
  endtask

  task fin;
    @(posedge CLK) STACK_DONE <= 1'b1;
    @(posedge CLK) STACK_DONE <= 1'b0;
    repeat (2) @(posedge CLK);
    chk(EXC_ACTIVE, 0);
  endtask

  task pulse_push;
    @(posedge CLK) PUSH_FAULT <= 1'b1;
    @(posedge CLK) PUSH_FAULT <= 1'b0;
  endtask

  task t_regs;
    apb(0, `AFE_OFF_VBASE, 0);
    chk(rd, `AFE_VBASE_RST);
    apb(1, `AFE_OFF_VBASE, VB);
    apb(0, `AFE_OFF_VBASE, 0);
    chk(rd, VB);
    apb(0, 12'h020, 0);
    chk(er, 1);
    pulse_push;
    @(posedge CLK);
    chk(CANCEL_DCACHE, 1);
    ex(8'h02);
    fin;
  endtask

  task t_bus;
    u_afe_bus_model.run(CYC_WRITE, 1, 0);
    ex(8'h02);
    apb(0, `AFE_OFF_FRAME, 0);
    chk(rd[27:16], 12'h702);
    fin;
    EU_REQ_MASK <= 4'b0001;
    u_afe_bus_model.run(CYC_LINE, 4, 2);
    repeat (6) @(posedge CLK);
    chk(la, 1);
    chk(EXC_ACTIVE, 0);
    EU_REQ_MASK <= 4'b0100;
    u_afe_bus_model.run(CYC_LINE, 4, 2);
    ex(8'h02);
    fin;
    u_afe_bus_model.run(CYC_READ, 1, 0);
    ex(8'h02);
    fin;
  endtask

  task t_xlat;
    for (int i = 0; i < 3; i++) begin
      @(posedge CLK) {XLAT_VALID, XLAT_WRITE, PAGE_WP, PAGE_SUPER, PAGE_RESIDENT} <= {1'b1, i == 0, i == 0, i == 1, i != 2};
      @(posedge CLK) {XLAT_VALID, PAGE_WP, PAGE_SUPER, PAGE_RESIDENT} <= 4'b0001;
      ex(8'h02);
      fin;
    end
    @(posedge CLK) {XLAT_VALID, XLAT_MISS} <= 2'b11;
    @(posedge CLK) {XLAT_VALID, XLAT_MISS, WALK_INVALID} <= 3'b001;
    @(posedge CLK) {XLAT_RETRY, WALK_INVALID} <= 2'b10;
    @(posedge CLK) XLAT_RETRY <= 1'b0;
    ex(8'h02);
    fin;
  endtask

  task t_fetch;
    u_afe_bus_model.run(CYC_FETCH, 1, 0);
    repeat (3) @(posedge CLK);
    chk(EXC_ACTIVE, 0);
    @(posedge CLK) CHANGE_OF_FLOW <= 1'b1;
    @(posedge CLK) {CHANGE_OF_FLOW, PREFETCH_USE} <= 2'b01;
    @(posedge CLK) PREFETCH_USE <= 1'b0;
    repeat (4) @(posedge CLK);
    chk(EXC_ACTIVE, 0);
    u_afe_bus_model.run(CYC_FETCH, 1, 0);
    // Pin error needs the synchroniser before the flag is set
    repeat (2) @(posedge CLK);
    @(posedge CLK) PREFETCH_USE <= 1'b1;
    @(posedge CLK) PREFETCH_USE <= 1'b0;
    ex(8'h02);
    fin;
  endtask

  task t_addr;
    @(posedge CLK) {PREFETCH_REQ, PREFETCH_ADDR} <= {1'b1, 32'h0000_2000};
    @(posedge CLK) PREFETCH_ADDR <= 32'h0000_2001;
    @(posedge CLK) PREFETCH_REQ <= 1'b0;
    chk(PREFETCH_GO, 1);
    @(posedge CLK);
    chk(PREFETCH_GO, 0);
    ex(8'h03);
    apb(0, `AFE_OFF_FADDR, 0);
    chk(rd, 32'h0000_2000);
    apb(0, `AFE_OFF_SPC, 0);
    chk(rd, CUR_PC);
    fin;
  endtask

  task t_drop;
    EARLIER_PENDING <= 1'b1;
    @(posedge CLK) {XLAT_VALID, XLAT_WRITE, PAGE_WP} <= 3'b111;
    @(posedge CLK) {XLAT_VALID, PAGE_WP} <= 2'b00;
    @(posedge CLK) EARLIER_EXC <= 1'b1;
    @(posedge CLK) {EARLIER_EXC, EARLIER_PENDING} <= 2'b00;
    repeat (4) @(posedge CLK);
    chk(fd, 1);
    chk(EXC_ACTIVE, 0);
  endtask

  task t_double;
    RTE_RELOAD <= 1'b1;
    u_afe_bus_model.run(CYC_READ, 1, 0);
    wt(1);
    chk(PROCESSOR_STATUS_CODE, 4'h5);
    RTE_RELOAD <= 1'b0;
    pulse_push;
    repeat (4) @(posedge CLK);
    chk({HALTED, EXC_ACTIVE}, 2'b10);
    @(posedge CLK) RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk(HALTED, 0);
    pulse_push;
    wt(0);
    @(posedge CLK) {PREFETCH_REQ, PREFETCH_ADDR} <= {1'b1, 32'h0000_3003};
    @(posedge CLK) PREFETCH_REQ <= 1'b0;
    wt(1);
    chk(MEM_WRITE_INHIBIT, 1);
  endtask

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PREFETCH_CYC_BUSY, EARLIER_PENDING, EARLIER_EXC} = '0;
    {STACK_DONE, RTE_RELOAD, RESET_EXC_ACTIVE, PREFETCH_REQ, PREFETCH_ADDR, PREFETCH_USE} = '0;
    {CHANGE_OF_FLOW, XLAT_VALID, XLAT_MISS, XLAT_WRITE, XLAT_SUPER_ACC, PAGE_WP, PAGE_SUPER} = '0;
    {XLAT_RETRY, WALK_INVALID, PUSH_FAULT, EU_REQ_MASK} = '0;
    {BUS_IDLE, EU_IDLE, PAGE_RESIDENT} = 3'b111;
    {CUR_PC, STATUS_WORD_IN, PEND_WRITES, MOVE_MULTIPLE_STATE} = {32'h0000_0F10, 16'hC0FF, 2'h3, 8'h5A};
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    t_regs;
    t_bus;
    t_xlat;
    t_fetch;
    t_addr;
    t_drop;
    t_double;
    report_and_stop;
  end
endmodule // tb_access_fault_address_error_unit
